// >>> verilog/adcc_top.sv
`timescale 1ns/10ps
`include "adcc_consts.svh"
// Overview of operation
// RQ1: Power bit powers converter up or down
// RQ2: Reference select picks external or internal reference
// RQ3: Divide bits pick master clock ratio
// RQ4: Software keeps converter clock within limit
// RQ5: Conversion lasts seventeen converter clocks
// RQ6: Acquisition lasts one to four converter clocks
// RQ7: Software should pick three acquisition clocks
// RQ8: Timer overflow starts conversion when enabled
// RQ9: Low pin pulse starts conversion when enabled
// RQ10: Pin pulse exceeds minimum width per sample
// RQ11: Result carries twelve bits plus channel tag
// RQ12: Straight binary result, full scale over 4096
// RQ13: Control one resets to all zeros
// RQ14: Single and continuous modes, any start source
// RQ15: DMA mode streams samples to external memory
// RQ16: Calibration coefficients load after power up
// RQ17: Eight channels plus temperature input
// RQ18: Done flag set at end, cleared by vector
// RQ19: Single request bit self clears when done
// RQ20: Channel select sampled when conversion starts
// RQ21: Start sources merged, ignored while busy
// RQ22: Busy spans conversion, result and flag together
module adcc_top
#(
	parameter logic [7:0] CAL_OFFSET_INIT = 8'h80, // Arbitrary factory value
	parameter logic [7:0] CAL_GAIN_INIT = 8'h80 // Arbitrary factory value
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic timer2_overflow,
	input wire logic convert_start_pin_n,
	input wire logic irq_vector_ack,
	input wire logic [11:0] sar_result,
	output logic converter_power_on,
	output logic reference_select,
	output logic [3:0] mux_select,
	output logic track_hold,
	output logic busy,
	output logic conversion_done_flag,
	output logic xmem_wr,
	output logic [23:0] xmem_addr,
	output logic [15:0] xmem_data,
	output logic cal_load,
	output logic [7:0] cal_offset,
	output logic [7:0] cal_gain
);
	import adcc_pkg::*;

	logic [1:0] rst_sync;
	logic rst_n;
	adcc_state_t st_reg;
	adcc_state_t st_next;
	adcc_tick_if tk ();
	logic wr_c1;
	logic wr_c2;
	logic wr_len;
	logic start_req;
	logic finish;
	logic [1:0] aq;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	adcc_clkdiv u_div
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tk(tk)
	);

	assign tk.div_code = {st_reg.ctl1[`ADCC_C1_CK_HI], st_reg.ctl1[`ADCC_C1_CK_LO]};
	assign tk.run = st_reg.run;
	assign aq = st_reg.ctl1[`ADCC_C1_AQ_HI:`ADCC_C1_AQ_LO];

	always_comb
	begin
		wr_c1 = sfr_wr && (sfr_addr == `ADCC_ADDR_CTL1);
		wr_c2 = sfr_wr && (sfr_addr == `ADCC_ADDR_CTL2);
		wr_len = sfr_wr && (sfr_addr == `ADCC_ADDR_DMA_LEN);
		st_next = st_reg;
		st_next.xmem_wr = 1'b0;
		st_next.cal_load = 1'b0;
		finish = 1'b0;

		// Coefficients go out once, the cycle after reset release
		if (!st_reg.cal_done) // see RQ16
		begin
			st_next.cal_done = 1'b1;
			st_next.cal_load = 1'b1;
			st_next.cal_offset = CAL_OFFSET_INIT;
			st_next.cal_gain = CAL_GAIN_INIT;
		end

		if (wr_c1)
			st_next.ctl1 = sfr_wdata; // see RQ1
		if (wr_len)
			st_next.dma_len = sfr_wdata;
		if (wr_c2)
		begin
			st_next.dma = sfr_wdata[`ADCC_C2_DMA];
			st_next.cont = sfr_wdata[`ADCC_C2_CONT];
			st_next.single = sfr_wdata[`ADCC_C2_SINGLE];
			st_next.cs = sfr_wdata[`ADCC_C2_CS_HI:`ADCC_C2_CS_LO];
			if (sfr_wdata[`ADCC_C2_DMA] && !st_reg.dma)
			begin
				st_next.dma_addr = 24'h00_0000;
				st_next.dma_cnt = 8'h00;
			end
		end

		// Pin inputs are synchronous, so a plain falling edge marks the low pulse
		st_next.pin_prev = convert_start_pin_n;
		start_req = st_reg.single || st_reg.cont || st_reg.dma
			|| (st_reg.ctl1[`ADCC_C1_TIMER] && timer2_overflow) // see RQ8
			|| (st_reg.ctl1[`ADCC_C1_PIN] && st_reg.pin_prev
			&& !convert_start_pin_n); // see RQ9, RQ14, RQ21

		unique case (st_reg.phase)
			ADCC_IDLE:
			begin
				if (start_req && st_reg.ctl1[`ADCC_C1_POWER] && st_reg.cal_done) // see RQ21
				begin
					st_next.phase = ADCC_ACQ;
					st_next.chan = st_reg.cs; // see RQ20
					st_next.ticks = 5'h00;
					st_next.run = 1'b1;
					st_next.busy = 1'b1; // see RQ22
					st_next.track = 1'b1;
				end
			end
			ADCC_ACQ:
			begin
				if (tk.tick)
				begin
					if (st_reg.ticks == {3'b000, aq}) // see RQ6
					begin
						st_next.phase = ADCC_CONV;
						st_next.ticks = 5'h00;
						st_next.track = 1'b0;
					end
					else
						st_next.ticks = st_reg.ticks + 5'h01;
				end
			end
			ADCC_CONV:
			begin
				// A power-down in flight must not finish with a result or a flag
				if (tk.tick && st_reg.ctl1[`ADCC_C1_POWER]) // see RQ1
				begin
					if (st_reg.ticks == `ADCC_CONV_TICKS - 5'h01) // see RQ5
						finish = 1'b1;
					else
						st_next.ticks = st_reg.ticks + 5'h01;
				end
			end
			default:
				st_next.phase = ADCC_IDLE;
		endcase

		if (finish)
		begin
			st_next.phase = ADCC_IDLE;
			st_next.run = 1'b0;
			st_next.busy = 1'b0;
			// Sar code is passed as straight binary, one step per FS/4096
			st_next.result = {st_reg.chan, sar_result}; // see RQ11, RQ12, RQ22
			if (st_reg.single && !(wr_c2 && sfr_wdata[`ADCC_C2_SINGLE]))
				st_next.single = 1'b0; // see RQ19
			if (st_reg.dma)
			begin
				st_next.xmem_wr = 1'b1; // see RQ15
				st_next.xmem_addr = st_reg.dma_addr;
				st_next.xmem_data = {st_reg.chan, sar_result};
				st_next.dma_addr = st_reg.dma_addr + `ADCC_DMA_STEP;
				st_next.dma_cnt = st_reg.dma_cnt + 8'h01;
				if (st_reg.dma_cnt + 8'h01 >= st_reg.dma_len)
					st_next.dma = 1'b0;
			end
		end

		// Powering down aborts a conversion in flight without a result
		if (!st_reg.ctl1[`ADCC_C1_POWER] && st_reg.phase != ADCC_IDLE) // see RQ1
		begin
			st_next.phase = ADCC_IDLE;
			st_next.run = 1'b0;
			st_next.busy = 1'b0;
			st_next.track = 1'b0;
		end

		// Hardware set wins over a software or vector clear in the same cycle
		if (wr_c2)
			st_next.done = sfr_wdata[`ADCC_C2_DONE];
		if (irq_vector_ack)
			st_next.done = 1'b0;
		if (finish && (!st_reg.dma || st_next.dma == 1'b0))
			st_next.done = 1'b1; // see RQ18

		st_next.rdata = st_reg.rdata;
		if (sfr_rd)
		begin
			unique case (sfr_addr)
				`ADCC_ADDR_CTL1: st_next.rdata = st_reg.ctl1;
				`ADCC_ADDR_CTL2: st_next.rdata = {st_reg.done, st_reg.dma, st_reg.cont,
					st_reg.single, st_reg.cs};
				`ADCC_ADDR_RES_LO: st_next.rdata = st_reg.result[7:0];
				`ADCC_ADDR_RES_HI: st_next.rdata = st_reg.result[15:8]; // see RQ11
				`ADCC_ADDR_DMA_LEN: st_next.rdata = st_reg.dma_len;
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.ctl1 <= `ADCC_CTL1_RESET; // see RQ13
			st_reg.dma_len <= `ADCC_DMA_LEN_RESET;
			st_reg.phase <= ADCC_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign sfr_rdata = st_reg.rdata;
	assign converter_power_on = st_reg.ctl1[`ADCC_C1_POWER]; // see RQ1
	assign reference_select = st_reg.ctl1[`ADCC_C1_REF]; // see RQ2
	// Codes above the temperature input are passed on; the mux ignores them
	assign mux_select = st_reg.chan; // see RQ17
	assign track_hold = st_reg.track;
	assign busy = st_reg.busy;
	assign conversion_done_flag = st_reg.done;
	assign xmem_wr = st_reg.xmem_wr;
	assign xmem_addr = st_reg.xmem_addr;
	assign xmem_data = st_reg.xmem_data;
	assign cal_load = st_reg.cal_load;
	assign cal_offset = st_reg.cal_offset;
	assign cal_gain = st_reg.cal_gain;
endmodule

// >>> pkg/adcc_consts.svh
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// Register addresses on the core's special function register port
`define ADCC_ADDR_CTL1 8'hEF
`define ADCC_ADDR_CTL2 8'hD8
`define ADCC_ADDR_RES_LO 8'hD9
`define ADCC_ADDR_RES_HI 8'hDA
`define ADCC_ADDR_DMA_LEN 8'hDB

`define ADCC_CTL1_RESET 8'h00
`define ADCC_CTL2_RESET 8'h00
`define ADCC_DMA_LEN_RESET 8'h00

// Control one fields
`define ADCC_C1_POWER 7
`define ADCC_C1_REF 6
`define ADCC_C1_CK_HI 5
`define ADCC_C1_CK_LO 4
`define ADCC_C1_AQ_HI 3
`define ADCC_C1_AQ_LO 2
`define ADCC_C1_TIMER 1
`define ADCC_C1_PIN 0

// Control two fields
`define ADCC_C2_DONE 7
`define ADCC_C2_DMA 6
`define ADCC_C2_CONT 5
`define ADCC_C2_SINGLE 4
`define ADCC_C2_CS_HI 3
`define ADCC_C2_CS_LO 0

// Converter clock timing, temperature channel code and DMA address step
`define ADCC_DIV_00 6'h08
`define ADCC_DIV_01 6'h04
`define ADCC_DIV_10 6'h10
`define ADCC_DIV_11 6'h20
`define ADCC_CONV_TICKS 5'h11
`define ADCC_CHAN_TEMP 4'h8
`define ADCC_DMA_STEP 24'h00_0002

`endif

// >>> pkg/adcc_pkg.sv
package adcc_pkg;

	typedef enum logic [1:0]
	{
		ADCC_IDLE = 2'b00,
		ADCC_ACQ = 2'b01,
		ADCC_CONV = 2'b10
	} adcc_phase_t;

	typedef struct packed
	{
		logic [5:0] cnt;
		logic tick;
	} adcc_div_state_t;

	typedef struct packed
	{
		logic [7:0] ctl1;
		logic done;
		logic dma;
		logic cont;
		logic single;
		logic [3:0] cs;
		logic [7:0] dma_len;
		logic [7:0] dma_cnt;
		logic [23:0] dma_addr;
		logic [15:0] result;
		adcc_phase_t phase;
		logic [4:0] ticks;
		logic [3:0] chan;
		logic pin_prev;
		logic busy;
		logic track;
		logic run;
		logic [7:0] rdata;
		logic xmem_wr;
		logic [23:0] xmem_addr;
		logic [15:0] xmem_data;
		logic cal_done;
		logic cal_load;
		logic [7:0] cal_offset;
		logic [7:0] cal_gain;
	} adcc_state_t;

endpackage

// >>> pkg/adcc_tick_if.sv
`timescale 1ns/10ps
interface adcc_tick_if;
	logic [1:0] div_code;
	logic run;
	logic tick;

	modport master
	(
		output div_code,
		output run,
		input tick
	);

	modport divider
	(
		input div_code,
		input run,
		output tick
	);
endinterface

// >>> verilog/adcc_clkdiv.sv
`timescale 1ns/10ps
`include "adcc_consts.svh"
module adcc_clkdiv
(
	input wire logic clk_sys,
	input wire logic rst_n,
	adcc_tick_if.divider tk
);
	import adcc_pkg::*;

	adcc_div_state_t st_reg;
	adcc_div_state_t st_next;
	logic [5:0] ratio;

	always_comb
	begin
		unique case (tk.div_code) // see RQ3
			2'b00: ratio = `ADCC_DIV_00;
			2'b01: ratio = `ADCC_DIV_01;
			2'b10: ratio = `ADCC_DIV_10;
			2'b11: ratio = `ADCC_DIV_11;
		endcase
		st_next = st_reg;
		st_next.tick = 1'b0;
		// Counter restarts with each conversion so the first period is whole
		if (!tk.run)
			st_next.cnt = 6'h00;
		else if (st_reg.cnt == ratio - 6'h01)
		begin
			st_next.cnt = 6'h00;
			st_next.tick = 1'b1;
		end
		else
			st_next.cnt = st_reg.cnt + 6'h01;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tk.tick = st_reg.tick;
endmodule

// >>> tb/adcc_properties.sv
`timescale 1ns/10ps
module adcc_properties
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic converter_power_on,
	input wire logic reference_select,
	input wire logic [3:0] mux_select,
	input wire logic track_hold,
	input wire logic busy,
	input wire logic conversion_done_flag,
	input wire logic xmem_wr,
	input wire logic [15:0] xmem_data,
	input wire logic cal_load
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	wire w1 = sfr_wr && sfr_addr == 8'hEF;
	logic [9:0] len;
	// Length of the busy span, so short and long conversions can both be bounded
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			len <= 10'h000;
		else
			len <= busy ? len + 10'h001 : 10'h000;
	property p_pw;
		w1 |=> converter_power_on == $past(sfr_wdata[7]);
	endproperty
	a_pw: assert property (p_pw) else $error("power bit wrong");
	property p_ref;
		w1 |=> reference_select == $past(sfr_wdata[6]);
	endproperty
	a_ref: assert property (p_ref) else $error("reference bit wrong");
	property p_off;
		!converter_power_on && !busy |=> !busy;
	endproperty
	a_off: assert property (p_off) else $error("start while off");
	property p_trk;
		$rose(busy) |-> track_hold[*4];
	endproperty
	a_trk: assert property (p_trk) else $error("track too short");
	property p_len;
		$fell(busy) && converter_power_on |-> len >= 10'h048 && len <= 10'h2A2;
	endproperty
	a_len: assert property (p_len) else $error("busy length wrong");
	property p_end;
		$rose(busy) |-> ##[1:700] !busy;
	endproperty
	a_end: assert property (p_end) else $error("conversion hangs");
	property p_done;
		$fell(busy) && converter_power_on && !xmem_wr |-> conversion_done_flag;
	endproperty
	a_done: assert property (p_done) else $error("done flag missing");
	property p_xm;
		xmem_wr |-> !busy && xmem_data[15:12] == mux_select;
	endproperty
	a_xm: assert property (p_xm) else $error("sample word wrong");
	property p_mux;
		busy && $past(busy) |-> $stable(mux_select);
	endproperty
	a_mux: assert property (p_mux) else $error("channel moved");
	property p_cal;
		cal_load |=> !cal_load;
	endproperty
	a_cal: assert property (p_cal) else $error("cal load repeats");
	c_done: cover property ($fell(busy));
	c_dma: cover property (xmem_wr);
	c_cal: cover property (cal_load);
endmodule
bind adcc_top adcc_properties u_props(.*);

// >>> tb/adcc_sar_model.sv
`timescale 1ns/10ps
module adcc_sar_model
(
	input wire logic clk_sys,
	input wire logic converter_power_on,
	input wire logic [3:0] mux_select,
	output logic [11:0] sar_result
);
	logic [11:0] junk = 12'hAAA;
	// Unpowered core shows noise so a stale code cannot pass
	always_ff @(posedge clk_sys)
		junk <= ~junk;
	assign sar_result = converter_power_on ? {8'h96, mux_select} : junk;
endmodule

// >>> tb/adcc_top_tb_top.sv
`timescale 1ns/10ps
module adcc_top_tb_top;
	logic clk_sys = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, timer2_overflow = 0;
	logic convert_start_pin_n = 1, irq_vector_ack = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, cal_offset, cal_gain, d;
	logic [11:0] sar_result;
	logic [3:0] mux_select;
	logic [23:0] xmem_addr;
	logic [15:0] xmem_data;
	logic converter_power_on, reference_select, track_hold, busy;
	logic conversion_done_flag, xmem_wr, cal_load;
	int bad_count = 0, cmp_count = 0, cyc = 0, n, k;
	adcc_top uut(.*);
	adcc_sar_model sar(.*);
	initial
		forever #2.5 clk_sys = ~clk_sys;
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic tk(int m = 1);
		repeat (m) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1;
		tk();
		sfr_wr = 0;
		tk();
	endtask
	task automatic rd(logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1;
		tk();
		sfr_rd = 0;
		d = sfr_rdata;
		tk();
	endtask
	task automatic wt;
		n = 0;
		while (busy === 1'b1 && n < 800)
		begin
			n++;
			tk();
		end
	endtask
	task automatic ack;
		irq_vector_ack = 1;
		tk();
		irq_vector_ack = 0;
		chk("done_clr", conversion_done_flag, 0);
	endtask
	task automatic s_conv(logic [1:0] c, logic [3:0] ch);
		int r;
		r = c == 0 ? 8 : c == 1 ? 4 : c == 2 ? 16 : 32;
		wr(8'hEF, {2'b10, c, c, 2'b00});
		wr(8'hD8, {4'h1, ch});
		wt();
		chk("busy_len", n, r * (c + 18) + 1);
		chk("mux", mux_select, ch);
		rd(8'hD8);
		chk("ctl2", d, {4'h8, ch});
		rd(8'hD9);
		chk("res_lo", d, {4'h6, ch});
		rd(8'hDA);
		chk("res_hi", d, {ch, 4'h9});
		ack();
	endtask
	task automatic pulse(logic en);
		timer2_overflow = 1;
		tk();
		timer2_overflow = 0;
		chk("timer", busy, en);
		wt();
		convert_start_pin_n = 0;
		tk(21);
		convert_start_pin_n = 1;
		chk("pin", busy, en);
		wt();
	endtask
	task automatic s_cont;
		wr(8'hD8, 8'h25);
		k = 0;
		repeat (200)
		begin
			tk();
			if (busy === 1'b0)
				k++;
		end
		chk("restarts", k, 2);
		ack();
		wr(8'hEF, 8'h10);
		chk("abort", busy, 0);
		tk(80);
		rd(8'hD8);
		chk("no_flag", d, 8'h25);
		rd(8'hDA);
		chk("cont_hi", d, 8'h59);
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#1;
		reset_n = 1;
		tk(4);
		chk("cal", cal_offset, 8'h80);
		chk("cal_gain", cal_gain, 8'h80);
		rd(8'hEF);
		chk("ctl1_rst", d, 8'h00);
		rd(8'h00);
		chk("unmapped", d, 8'h00);
		wr(8'hEF, 8'h40);
		chk("ref", reference_select, 1);
		wr(8'hD8, 8'h10);
		tk(3);
		chk("off", busy, 0);
		wr(8'hD8, 8'h00);
		for (int c = 0; c < 4; c++)
			s_conv(c[1:0], c == 3 ? 4'h8 : c[3:0]);
		wr(8'hEF, 8'h80);
		pulse(0);
		wr(8'hEF, 8'h83);
		pulse(1);
		ack();
		wr(8'hDB, 8'h02);
		wr(8'hEF, 8'h98);
		wr(8'hD8, 8'h43);
		k = 0;
		repeat (400)
		begin
			tk();
			if (xmem_wr === 1'b1)
			begin
				chk("xaddr", xmem_addr, 2 * k);
				chk("xdata", xmem_data, 16'h3963);
				k++;
			end
		end
		chk("samples", k, 2);
		rd(8'hD8);
		chk("dma_end", d, 8'h83);
		s_cont();
		summarize();
	end
endmodule
